// ### logic/clkgc_pkg.sv
package clkgc_pkg;

	// Register word offsets on the bus
	localparam logic [3:0] CLKGC_PIN_MODE_OFS  = 4'h0;
	localparam logic [3:0] CLKGC_OSC_RUN_OFS   = 4'h4;
	localparam logic [3:0] CLKGC_SYS_SEL_OFS   = 4'h8;
	localparam logic [3:0] CLKGC_SUPPLY_OFS    = 4'hc;

	// Values after reset: external sources stopped, internal fast oscillator running
	localparam logic [7:0] CLKGC_PIN_MODE_RST  = 8'h00;
	localparam logic [7:0] CLKGC_OSC_RUN_RST   = 8'hc0;
	localparam logic [7:0] CLKGC_SYS_SEL_RST   = 8'h00;
	localparam logic [7:0] CLKGC_SUPPLY_RST    = 8'h00;

	// Writable and readable bits; all others are fixed zero, except select bits 7 and 5, which read the switch status
	localparam logic [7:0] CLKGC_PIN_MODE_MASK = 8'hf7;
	localparam logic [7:0] CLKGC_OSC_RUN_MASK  = 8'hc1;
	localparam logic [7:0] CLKGC_SYS_SEL_WMASK = 8'h50;
	localparam logic [7:0] CLKGC_SUPPLY_MASK   = 8'h90;

	// Field positions
	localparam int CLKGC_MAIN_MODE_HI   = 7;
	localparam int CLKGC_MAIN_MODE_LO   = 6;
	localparam int CLKGC_SUB_MODE_HI    = 5;
	localparam int CLKGC_SUB_MODE_LO    = 4;
	localparam int CLKGC_SUB_DRIVE_HI   = 2;
	localparam int CLKGC_SUB_DRIVE_LO   = 1;
	localparam int CLKGC_MAIN_FREQ_BIT  = 0;
	localparam int CLKGC_MAIN_HALT_BIT  = 7;
	localparam int CLKGC_SUB_HALT_BIT   = 6;
	localparam int CLKGC_FAST_HALT_BIT  = 0;
	localparam int CLKGC_CPU_STAT_BIT   = 7;
	localparam int CLKGC_CPU_SEL_BIT    = 6;
	localparam int CLKGC_MAIN_STAT_BIT  = 5;
	localparam int CLKGC_MAIN_SEL_BIT   = 4;
	localparam int CLKGC_SUB_GATE_BIT   = 7;
	localparam int CLKGC_TIMER_SEL_BIT  = 4;

	// Pin mode and drive codes
	localparam logic [1:0] CLKGC_MODE_OSC        = 2'h1;
	localparam logic [1:0] CLKGC_MODE_EXT        = 2'h3;
	localparam logic [1:0] CLKGC_DRIVE_FORBIDDEN = 2'h3;

	// Switchover settle time
	localparam int CLKGC_CLK_PERIOD_NS  = 100;
	localparam int CLKGC_SETTLE_NS      = 800;
	localparam int CLKGC_SETTLE_CYCLES  =
		(CLKGC_SETTLE_NS + CLKGC_CLK_PERIOD_NS - 1) / CLKGC_CLK_PERIOD_NS;
	localparam logic [3:0] CLKGC_SETTLE_LAST = 4'(CLKGC_SETTLE_CYCLES - 1);

	typedef enum logic {CLKGC_SW_STABLE, CLKGC_SW_SETTLE} clkgc_sw_state_t;

	typedef struct packed {
		logic       main_osc_en;
		logic       main_ext_en;
		logic       main_port;
		logic       sub_osc_en;
		logic       sub_ext_en;
		logic       sub_port;
		logic [1:0] sub_drive;
		logic       main_freq_high;
		logic       fast_osc_en;
	} clkgc_osc_t;

	typedef struct packed {
		logic cpu_on_sub;
		logic main_on_high_speed;
		logic periph_sub_en;
		logic timer_on_slow;
	} clkgc_route_t;

endpackage

// ### logic/clkgc_sync.sv
`timescale 1ns/1ps
module clkgc_sync #(
	parameter int W = 3
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] stage1;

	// Two flops per bit; the first is read by the second only
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk) begin
			if (rst) begin
				stage1[i]   <= 1'b0;
				sync_out[i] <= 1'b0;
			end else if (ce) begin
				stage1[i]   <= async_in[i];
				sync_out[i] <= stage1[i];
			end
		end
	end
endmodule

// ### logic/clkgc_switch.sv
`timescale 1ns/1ps
module clkgc_switch (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic sel,
	input  wire logic tgt_ready,
	output logic      status
);
	clkgc_pkg::clkgc_sw_state_t state;
	logic [3:0]                 count;
	wire                        want = sel != status;

	// Status follows select only after the target ran steadily for the settle time
	always_ff @(posedge clk) begin
		if (rst) begin
			state  <= clkgc_pkg::CLKGC_SW_STABLE;
			count  <= 4'h0;
			status <= 1'b0;
		end else if (ce) begin
			case (state)
				clkgc_pkg::CLKGC_SW_STABLE: begin
					count <= 4'h0;
					if (want && tgt_ready) begin
						state <= clkgc_pkg::CLKGC_SW_SETTLE;
					end
				end
				clkgc_pkg::CLKGC_SW_SETTLE: begin
					// A lost source or withdrawn request aborts the switch
					if (!want || !tgt_ready) begin
						state <= clkgc_pkg::CLKGC_SW_STABLE;
					end else if (count == clkgc_pkg::CLKGC_SETTLE_LAST) begin
						status <= sel; // R15
						state  <= clkgc_pkg::CLKGC_SW_STABLE;
					end else begin
						count <= count + 4'h1;
					end
				end
				default: state <= clkgc_pkg::CLKGC_SW_STABLE;
			endcase
		end
	end

	sw_lag_a: assert property (@(posedge clk) disable iff (rst) // R15
		$changed(status) |-> $past(tgt_ready) && $past(state == clkgc_pkg::CLKGC_SW_SETTLE))
		else $error("status moved without a settled source");
	sw_hold_a: assert property (@(posedge clk) disable iff (rst) // R15
		(ce && !tgt_ready) |=> $stable(status))
		else $error("status moved while target not ready");
endmodule

// ### logic/clkgc_top.sv
// Behaviour
// R01: Main pin mode: port, oscillator, external clock.
// R02: Sub pin mode: port, oscillator, external clock.
// R03: Sub drive: low, normal, ultra-low; 11 refused.
// R04: Main range bit tunes 1-10 or 10-20 MHz.
// R05: Main halt bit stops oscillator or external input.
// R06: Sub halt bit stops oscillator or external input.
// R07: Fast internal oscillator halt bit stops it.
// R08: CPU status reads actual main or sub source.
// R09: CPU select requests main or sub clock.
// R10: Main status reads fast oscillator or high-speed.
// R11: Main select picks fast oscillator or high-speed.
// R12: Standby gating limits sub clock to timers.
// R13: Timer count clock: sub or slow oscillator.
// R14: Fixed-zero bits read zero, writes ignored.
// R15: Status bits change after switchover completes.
`timescale 1ns/1ps
module clkgc_top (
	input  wire logic                    SYS_CLK,
	input  wire logic                    RST,
	input  wire logic                    CE,
	input  wire logic                    WB_CYC_I,
	input  wire logic                    WB_STB_I,
	input  wire logic                    WB_WE_I,
	input  wire logic [3:0]              WB_ADR_I,
	input  wire logic [3:0]              WB_SEL_I,
	input  wire logic [31:0]             WB_DAT_I,
	output logic      [31:0]             WB_DAT_O,
	output logic                         WB_ACK_O,
	input  wire logic                    MAIN_CLK_READY,
	input  wire logic                    SUB_CLK_READY,
	input  wire logic                    FAST_OSC_READY,
	input  wire logic                    STOP_MODE,
	input  wire logic                    HALT_MODE,
	output clkgc_pkg::clkgc_osc_t        OSC_CTRL,
	output clkgc_pkg::clkgc_route_t      CLK_ROUTE
);
	logic [7:0] pin_mode;
	logic [7:0] osc_run;
	logic [7:0] sys_sel;
	logic [7:0] supply;
	logic [2:0] ready_sync;
	logic       cpu_status;
	logic       main_status;

	// Bus decode
	wire        req        = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire        wr_lane    = req && WB_WE_I && WB_SEL_I[0];
	wire        hit_pin    = WB_ADR_I == clkgc_pkg::CLKGC_PIN_MODE_OFS;
	wire        hit_run    = WB_ADR_I == clkgc_pkg::CLKGC_OSC_RUN_OFS;
	wire        hit_sel    = WB_ADR_I == clkgc_pkg::CLKGC_SYS_SEL_OFS;
	wire        hit_supply = WB_ADR_I == clkgc_pkg::CLKGC_SUPPLY_OFS;
	wire [7:0]  wdata      = WB_DAT_I[7:0];

	// Forbidden drive code keeps the previous drive setting
	wire        drive_bad  = wdata[clkgc_pkg::CLKGC_SUB_DRIVE_HI:clkgc_pkg::CLKGC_SUB_DRIVE_LO]
		== clkgc_pkg::CLKGC_DRIVE_FORBIDDEN;
	wire [7:0]  drive_keep = 8'h06;
	wire [7:0]  pin_wr     = drive_bad ? ((wdata & ~drive_keep) | (pin_mode & drive_keep))
		: wdata; // R03

	// Fixed-zero bits are masked on write
	wire [7:0]  next_pin_mode = pin_wr & clkgc_pkg::CLKGC_PIN_MODE_MASK; // R14
	wire [7:0]  next_osc_run  = wdata & clkgc_pkg::CLKGC_OSC_RUN_MASK; // R14
	wire [7:0]  next_sys_sel  = wdata & clkgc_pkg::CLKGC_SYS_SEL_WMASK; // R14
	wire [7:0]  next_supply   = wdata & clkgc_pkg::CLKGC_SUPPLY_MASK; // R14

	// Live select readback: status bits come from the switch trackers
	wire [7:0]  sel_view;
	assign sel_view = sys_sel
		| (8'(cpu_status) << clkgc_pkg::CLKGC_CPU_STAT_BIT) // R08
		| (8'(main_status) << clkgc_pkg::CLKGC_MAIN_STAT_BIT); // R10

	// Read mux; unmapped offsets answer zero
	wire [7:0]  rd_byte = hit_pin    ? pin_mode :
		hit_run    ? osc_run  :
		hit_sel    ? sel_view :
		hit_supply ? supply   : 8'h00;

	// Registers written from the bus
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			pin_mode <= clkgc_pkg::CLKGC_PIN_MODE_RST;
			osc_run  <= clkgc_pkg::CLKGC_OSC_RUN_RST;
			sys_sel  <= clkgc_pkg::CLKGC_SYS_SEL_RST;
			supply   <= clkgc_pkg::CLKGC_SUPPLY_RST;
		end else if (CE && wr_lane) begin
			if (hit_pin) begin
				pin_mode <= next_pin_mode;
			end
			if (hit_run) begin
				osc_run <= next_osc_run;
			end
			if (hit_sel) begin
				sys_sel <= next_sys_sel;
			end
			if (hit_supply) begin
				supply <= next_supply;
			end
		end
	end

	// One-wait-state answer, dropped the cycle after
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else if (CE) begin
			WB_ACK_O <= req;
			WB_DAT_O <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// Bus side: zero data outside the answer, fixed-zero bits never stored
	idle_data_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
		else $error("read data driven outside ack");
	upper_lane_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R14
		WB_DAT_O[31:8] == 24'h00_0000)
		else $error("upper read lanes not zero");
	fixed_zero_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R14
		!pin_mode[3] && (osc_run & 8'h3e) == 8'h00 && (sys_sel & 8'haf) == 8'h00
			&& (supply & 8'h6f) == 8'h00)
		else $error("fixed-zero register bit set");

	// Ready pins come from free oscillators, so they are synchronised first
	clkgc_sync #(
		.W(3)
	) u_sync (
		.clk      (SYS_CLK),
		.rst      (RST),
		.ce       (CE),
		.async_in ({FAST_OSC_READY, SUB_CLK_READY, MAIN_CLK_READY}),
		.sync_out (ready_sync)
	);

	// Field views
	wire [1:0]  main_mode = pin_mode[clkgc_pkg::CLKGC_MAIN_MODE_HI:clkgc_pkg::CLKGC_MAIN_MODE_LO];
	wire [1:0]  sub_mode  = pin_mode[clkgc_pkg::CLKGC_SUB_MODE_HI:clkgc_pkg::CLKGC_SUB_MODE_LO];
	wire        main_halt = osc_run[clkgc_pkg::CLKGC_MAIN_HALT_BIT];
	wire        sub_halt  = osc_run[clkgc_pkg::CLKGC_SUB_HALT_BIT];
	wire        fast_halt = osc_run[clkgc_pkg::CLKGC_FAST_HALT_BIT];

	// Codes 00 and 10 leave the pins as ports
	wire        main_is_osc = main_mode == clkgc_pkg::CLKGC_MODE_OSC; // R01
	wire        main_is_ext = main_mode == clkgc_pkg::CLKGC_MODE_EXT; // R01
	wire        sub_is_osc  = sub_mode == clkgc_pkg::CLKGC_MODE_OSC; // R02
	wire        sub_is_ext  = sub_mode == clkgc_pkg::CLKGC_MODE_EXT; // R02

	// Source running and stable, as seen through the ready pins
	wire        high_speed_ok = (main_is_osc || main_is_ext) && !main_halt && ready_sync[0]; // R05
	wire        sub_ok        = (sub_is_osc || sub_is_ext) && !sub_halt && ready_sync[1]; // R06
	wire        fast_ok       = !fast_halt && ready_sync[2]; // R07

	// Main source tracker: fast oscillator or high-speed clock
	wire        main_sel   = sys_sel[clkgc_pkg::CLKGC_MAIN_SEL_BIT];
	wire        main_ready = main_sel ? high_speed_ok : fast_ok; // R11
	clkgc_switch u_main_sw (
		.clk       (SYS_CLK),
		.rst       (RST),
		.ce        (CE),
		.sel       (main_sel),
		.tgt_ready (main_ready),
		.status    (main_status)
	);

	// CPU source tracker: main system clock or subsystem clock
	wire        cpu_sel   = sys_sel[clkgc_pkg::CLKGC_CPU_SEL_BIT];
	wire        main_live = main_status ? high_speed_ok : fast_ok;
	wire        cpu_ready = cpu_sel ? sub_ok : main_live; // R09
	clkgc_switch u_cpu_sw (
		.clk       (SYS_CLK),
		.rst       (RST),
		.ce        (CE),
		.sel       (cpu_sel),
		.tgt_ready (cpu_ready),
		.status    (cpu_status)
	);

	// A status bit only ever moves onto the source that is requested
	main_follow_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R11
		$changed(main_status) |-> main_status == $past(sys_sel[4]))
		else $error("main status moved away from its select");
	cpu_follow_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R09
		$changed(cpu_status) |-> cpu_status == $past(sys_sel[6]))
		else $error("cpu status moved away from its select");

	// Standby gating of the sub clock towards peripherals
	wire        standby     = STOP_MODE || (HALT_MODE && cpu_status);
	wire        gate_on     = supply[clkgc_pkg::CLKGC_SUB_GATE_BIT];
	wire        next_periph = !(standby && gate_on); // R12
	wire        timer_slow  = supply[clkgc_pkg::CLKGC_TIMER_SEL_BIT]; // R13

	// Oscillator controls; a halted external input is simply ignored
	clkgc_pkg::clkgc_osc_t next_osc;
	always_comb begin
		next_osc                = '0;
		next_osc.main_osc_en    = main_is_osc && !main_halt; // R05
		next_osc.main_ext_en    = main_is_ext && !main_halt; // R05
		next_osc.main_port      = !main_is_osc && !main_is_ext; // R01
		next_osc.sub_osc_en     = sub_is_osc && !sub_halt; // R06
		next_osc.sub_ext_en     = sub_is_ext && !sub_halt; // R06
		next_osc.sub_port       = !sub_is_osc && !sub_is_ext; // R02
		next_osc.sub_drive      = pin_mode[clkgc_pkg::CLKGC_SUB_DRIVE_HI:
			clkgc_pkg::CLKGC_SUB_DRIVE_LO]; // R03
		next_osc.main_freq_high = pin_mode[clkgc_pkg::CLKGC_MAIN_FREQ_BIT]; // R04
		next_osc.fast_osc_en    = !fast_halt; // R07
	end

	// Outputs registered so the pads see clean levels
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			OSC_CTRL  <= '0;
			CLK_ROUTE <= '0;
		end else if (CE) begin
			OSC_CTRL                     <= next_osc;
			CLK_ROUTE.cpu_on_sub         <= cpu_status; // R08
			CLK_ROUTE.main_on_high_speed <= main_status; // R10
			CLK_ROUTE.periph_sub_en      <= next_periph; // R12
			CLK_ROUTE.timer_on_slow      <= timer_slow; // R13
		end
	end

	ack_pulse_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held longer than one cycle");
	ack_timing_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(CE && WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
		else $error("request not answered next cycle");
	drive_legal_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R03
		pin_mode[2:1] != clkgc_pkg::CLKGC_DRIVE_FORBIDDEN)
		else $error("forbidden drive code stored");
	zero_bits_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R14
		WB_ACK_O && $past(hit_run) |-> (WB_DAT_O[7:0] & 8'h3e) == 8'h00)
		else $error("fixed-zero bit read as one");
	main_enable_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R05
		CE |=> OSC_CTRL.main_osc_en == ($past(main_mode) == 2'h1 && !$past(main_halt)))
		else $error("main oscillator enable wrong");
	fast_halt_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R07
		(CE && fast_halt) |=> !OSC_CTRL.fast_osc_en)
		else $error("fast oscillator runs while halted");
	periph_gate_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R12
		(CE && STOP_MODE && gate_on) |=> !CLK_ROUTE.periph_sub_en)
		else $error("sub clock reaches peripherals in gated standby");
	timer_sel_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R13
		CE |=> CLK_ROUTE.timer_on_slow == $past(supply[4]))
		else $error("timer count clock select not followed");
	cpu_status_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R08
		CE |=> CLK_ROUTE.cpu_on_sub == $past(cpu_status))
		else $error("cpu source status not reported");
	switch_wait_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R15
		$rose(main_status) |-> $past(main_sel) && $past(high_speed_ok, 2))
		else $error("main status rose before the source settled");

	// Oscillator controls follow the registers one cycle later
	main_port_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R01
		CE |=> OSC_CTRL.main_port == !$past(pin_mode[6]))
		else $error("main pins not ports in port mode");
	port_idle_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R01
		(CE && !pin_mode[6]) |=> !OSC_CTRL.main_osc_en && !OSC_CTRL.main_ext_en)
		else $error("main source enabled in port mode");
	main_ext_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R05
		CE |=> OSC_CTRL.main_ext_en ==
			($past(pin_mode[7:6]) == 2'h3 && !$past(osc_run[7])))
		else $error("main external input enable wrong");
	main_halt_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R05
		(CE && osc_run[7]) |=> !OSC_CTRL.main_osc_en && !OSC_CTRL.main_ext_en)
		else $error("main source runs while halted");
	sub_port_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R02
		CE |=> OSC_CTRL.sub_port == !$past(pin_mode[4]))
		else $error("sub pins not ports in port mode");
	sub_osc_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R06
		CE |=> OSC_CTRL.sub_osc_en ==
			($past(pin_mode[5:4]) == 2'h1 && !$past(osc_run[6])))
		else $error("sub oscillator enable wrong");
	sub_ext_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R06
		CE |=> OSC_CTRL.sub_ext_en ==
			($past(pin_mode[5:4]) == 2'h3 && !$past(osc_run[6])))
		else $error("sub external input enable wrong");
	sub_halt_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R06
		(CE && osc_run[6]) |=> !OSC_CTRL.sub_osc_en && !OSC_CTRL.sub_ext_en)
		else $error("sub source runs while halted");
	sub_drive_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R03
		CE |=> OSC_CTRL.sub_drive == $past(pin_mode[2:1]))
		else $error("sub drive setting not passed on");
	freq_range_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R04
		CE |=> OSC_CTRL.main_freq_high == $past(pin_mode[0]))
		else $error("main frequency range not passed on");
	fast_run_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R07
		(CE && !osc_run[0]) |=> OSC_CTRL.fast_osc_en)
		else $error("fast oscillator stopped while enabled");

	// Routing and standby gating
	main_route_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R10
		CE |=> CLK_ROUTE.main_on_high_speed == $past(main_status))
		else $error("main source status not reported");
	gate_open_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R12
		(CE && !supply[7]) |=> CLK_ROUTE.periph_sub_en)
		else $error("sub clock cut with gating off");
	awake_open_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R12
		(CE && !STOP_MODE && !HALT_MODE) |=> CLK_ROUTE.periph_sub_en)
		else $error("sub clock cut outside standby");
	halt_gate_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R12
		(CE && HALT_MODE && cpu_status && supply[7]) |=> !CLK_ROUTE.periph_sub_en)
		else $error("sub clock reaches peripherals in gated halt");

	// A CPU source switch finishes only on a settled target
	cpu_lag_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R15
		$rose(cpu_status) |-> $past(cpu_sel) && $past(sub_ok, 2))
		else $error("cpu status rose before the sub source settled");
	cpu_back_a: assert property (@(posedge SYS_CLK) disable iff (RST) // R15
		$fell(cpu_status) |-> !$past(cpu_sel) && $past(main_live, 2))
		else $error("cpu status fell before the main source settled");
endmodule

// ### tb/clkgc_src_model.sv
`timescale 1ns/1ps
module clkgc_src_model #(
	parameter int START = 12
) (
	input  wire logic                  clk,
	input  wire clkgc_pkg::clkgc_osc_t osc,
	output logic                       main_ready,
	output logic                       sub_ready,
	output logic                       fast_ready
);
	int main_cnt = 0;
	int sub_cnt  = 0;
	int fast_cnt = 0;

	// Resonators need a start-up run; any stop restarts it from zero
	always @(posedge clk) begin
		main_cnt <= osc.main_osc_en ? main_cnt + 1 : 0;
		sub_cnt  <= osc.sub_osc_en ? sub_cnt + 1 : 0;
		fast_cnt <= osc.fast_osc_en ? fast_cnt + 1 : 0;
	end

	// An external clock is usable as soon as its input is accepted
	assign main_ready = osc.main_ext_en || (osc.main_osc_en && main_cnt >= START);
	assign sub_ready  = osc.sub_ext_en || (osc.sub_osc_en && sub_cnt >= START);
	assign fast_ready = osc.fast_osc_en && fast_cnt >= 4;
endmodule

// ### tb/clock_generator_control_tb_top.sv
`timescale 1ns/1ps
module clock_generator_control_tb_top;
	logic                    sys_clk = 1'h0, rst = 1'h1, req = 1'h0, we = 1'h0;
	logic                    stop_m  = 1'h0, halt_m = 1'h0, ce = 1'h1;
	logic                    ack, mrdy, srdy, frdy;
	logic [3:0]              adr = 4'h0, sel = 4'h0;
	logic [3:0]              adr_tab [4] = '{4'h0, 4'h4, 4'h6, 4'hc};
	logic [31:0]             wdat = 32'h0, dat_o, rdat;
	clkgc_pkg::clkgc_osc_t   osc;
	clkgc_pkg::clkgc_route_t route;
	int                      bad_count = 0, cmp_count = 0, cycles = 0, seed = 32'hdaa6df76;
	int                      regs [4];
	int                      a, d, s;

	// Free-running 10 MHz clock
	always #50 sys_clk = ~sys_clk;

	clkgc_top dut (
		.SYS_CLK(sys_clk), .RST(rst), .CE(ce), .WB_CYC_I(req), .WB_STB_I(req),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .MAIN_CLK_READY(mrdy), .SUB_CLK_READY(srdy), .FAST_OSC_READY(frdy),
		.STOP_MODE(stop_m), .HALT_MODE(halt_m), .OSC_CTRL(osc), .CLK_ROUTE(route)
	);

	clkgc_src_model src (
		.clk(sys_clk), .osc(osc), .main_ready(mrdy), .sub_ready(srdy), .fast_ready(frdy)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Classic cycle: request held until ack is sampled high, data taken there
	task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] dt,
		input logic [3:0] sl);
		@(posedge sys_clk);
		req  <= 1'h1;
		we   <= w;
		adr  <= ad;
		wdat <= dt;
		sel  <= sl;
		do @(posedge sys_clk); while (ack !== 1'h1);
		rdat = dat_o;
		req <= 1'h0;
		we  <= 1'h0;
	endtask

	// Write plus the reference register model
	task automatic wr(input logic [3:0] ad, input logic [31:0] dt, input logic [3:0] sl);
		int i;
		i = ad >> 2;
		wb(1'h1, ad, dt, sl);
		if (sl[0] && ad[1:0] == 2'h0) begin
			case (i)
				0: regs[0] = (dt[2:1] == 2'h3) ? ((dt & 'hf1) | (regs[0] & 'h06)) : (dt & 'hf7);
				1: regs[1] = dt & 'hc1;
				3: regs[3] = dt & 'h90;
				default: ;
			endcase
		end
	endtask

	task automatic rchk(input logic [3:0] ad, input logic [31:0] exp);
		wb(1'h0, ad, 32'h0, 4'hf);
		chk(rdat, exp);
	endtask

	// Expected oscillator controls from pin mode and run registers
	function automatic logic [31:0] osc_exp();
		logic [7:0] p;
		logic [7:0] r;
		p = regs[0][7:0];
		r = regs[1][7:0];
		return {22'h0, p[7:6] == 2'h1 && !r[7], p[7:6] == 2'h3 && !r[7], !p[6],
			p[5:4] == 2'h1 && !r[6], p[5:4] == 2'h3 && !r[6], !p[4], p[2:1], p[0], !r[0]};
	endfunction

	// Cycle ceiling; a hung handshake ends here
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			results();
		end
	end

	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'h0;
		regs = '{clkgc_pkg::CLKGC_PIN_MODE_RST, clkgc_pkg::CLKGC_OSC_RUN_RST,
			clkgc_pkg::CLKGC_SYS_SEL_RST, clkgc_pkg::CLKGC_SUPPLY_RST};
		repeat (2) @(posedge sys_clk);
		chk(32'(osc), osc_exp());
		chk(32'(route), 32'h2);
		for (a = 0; a < 16; a += 4) rchk(4'(a), regs[a >> 2]);
		wr(4'h2, 32'hff, 4'hf);
		rchk(4'h2, 32'h0);
		// Every pin mode and drive code, running then halted
		for (a = 0; a < 32; a++) begin
			wr(4'h4, (a < 16) ? 32'h0 : 32'hc1, 4'h1);
			wr(4'h0, 32'(((a & 15) << 4) | ((a & 3) << 1) | (a >> 4)), 4'h1);
			rchk(4'h0, regs[0]);
			chk(32'(osc), osc_exp());
		end
		// Random traffic, lane-disabled and unmapped writes among it
		for (int n = 0; n < 40; n++) begin
			a = $random(seed);
			d = $random(seed);
			s = $random(seed);
			wr(adr_tab[a & 3], d, 4'(s));
			rchk(adr_tab[a & 3], ((a & 3) == 2) ? 32'h0 : regs[adr_tab[a & 3] >> 2]);
			chk(32'(osc), osc_exp());
			chk(32'(route[0]), 32'(regs[3][4]));
		end
		// Status follows select only once the new source has settled
		wr(4'h4, 32'h0, 4'h1);
		wr(4'h0, 32'h50, 4'h1);
		wr(4'hc, 32'h0, 4'h1);
		wait (mrdy && srdy);
		wr(4'h8, 32'h10, 4'h1);
		rchk(4'h8, 32'h10);
		repeat (12) @(posedge sys_clk);
		rchk(4'h8, 32'h30);
		wr(4'h8, 32'h50, 4'h1);
		rchk(4'h8, 32'h70);
		repeat (12) @(posedge sys_clk);
		rchk(4'h8, 32'hf0);
		chk(32'(route), 32'he);
		// Standby gating while the CPU runs from the sub clock
		for (a = 0; a < 8; a++) begin
			if (a == 4) wr(4'hc, 32'h80, 4'h1);
			stop_m <= a[0];
			halt_m <= a[1];
			repeat (2) @(posedge sys_clk);
			chk(32'(route[1]), 32'(!(a[2] && a[1:0] != 2'h0)));
		end
		// HALT alone is no standby once the CPU is back on the main clock
		stop_m <= 1'h0;
		halt_m <= 1'h1;
		wr(4'h8, 32'h10, 4'h1);
		repeat (12) @(posedge sys_clk);
		rchk(4'h8, 32'h30);
		chk(32'(route), 32'h6);
		// Enable low freezes a pending switch; it completes once enable returns
		wr(4'h8, 32'h50, 4'h1);
		ce <= 1'h0;
		repeat (20) @(posedge sys_clk);
		chk(32'(route[3]), 32'h0);
		ce <= 1'h1;
		repeat (12) @(posedge sys_clk);
		chk(32'(route), 32'hc);
		rchk(4'h8, 32'hf0);
		results();
	end
endmodule
